// *** common/sstc_map.svh ***
// Address map, field positions, reset values and masks of the timing bank.
// Assumes a 9-bit word address delivered by the serial configuration port.
`ifndef SSTC_MAP_SVH
`define SSTC_MAP_SVH

// Word addresses
`define SSTC_ADDR_INTEG 9'h0C2
`define SSTC_ADDR_WINDOW 9'h0C3
`define SSTC_ADDR_RSVD 9'h0C4
`define SSTC_ADDR_DARK 9'h0C5
`define SSTC_ADDR_FILLER 9'h0C6
`define SSTC_ADDR_MULT 9'h0C7
`define SSTC_ADDR_PERIOD 9'h0C8
`define SSTC_ADDR_INTEG_TIME 9'h0C9
`define SSTC_ADDR_SLOPE2_TIME 9'h0CA

// Reset values
`define SSTC_RST_INTEG 16'h0004
`define SSTC_RST_WINDOW 16'h0001
`define SSTC_RST_DARK 16'h0102
`define SSTC_RST_FILLER 16'h0000
`define SSTC_RST_MULT 16'h0001
`define SSTC_RST_PERIOD 16'h0000
`define SSTC_RST_TIME 16'h0000

// Implemented bits; all others read as zero
`define SSTC_MASK_INTEG 16'h0007
`define SSTC_MASK_WINDOW 16'h00FF
`define SSTC_MASK_DARK 16'h01FF
`define SSTC_MASK_FILLER 16'h0FFF

// Field positions
`define SSTC_BIT_DUAL 0
`define SSTC_BIT_TRIPLE 1
`define SSTC_BIT_KIND 2
`define SSTC_DARK_MSB 7
`define SSTC_BIT_BLANK 8
`define SSTC_WINDOW_MSB 7
`define SSTC_FILLER_MSB 11

// Counting constants
`define SSTC_DARK_MIN 8'h01
`define SSTC_ZERO16 16'h0000
`define SSTC_ONE16 16'h0001
`define SSTC_ZERO8 8'h00
`define SSTC_ONE8 8'h01

`endif

// *** common/sstc_pkg.sv ***
// Types shared by the timing bank and its test bench.
// Assumes nothing of its surroundings.
`default_nettype none

package sstc_pkg;

    typedef enum logic [1:0] {
        EX_IDLE,
        EX_FIRST,
        EX_SECOND,
        EX_PERIOD
    } sstc_expo_state_t;

    typedef enum logic {
        RD_IDLE,
        RD_WAIT
    } sstc_rd_state_t;

    typedef struct packed {
        logic dual_en;
        logic triple_en;
        logic period_is_frame;
        logic [7:0] window_mask;
        logic [7:0] dark_rows;
        logic blank_first;
        logic [11:0] filler_rows;
        logic [15:0] tick_mult;
        logic [15:0] period_len;
        logic [15:0] integ_time;
        logic [15:0] slope2_time;
    } sstc_cfg_t;

endpackage

`default_nettype wire

// *** core/sstc_tick_gen.sv ***
// Tick generator: one-cycle pulse every multiplier system clock cycles.
// Assumes a multiplier of zero is meant as one.
`include "sstc_map.svh"
`default_nettype none

module sstc_tick_gen (
    input wire logic i_clk,          // System clock
    input wire logic i_rst,          // Synchronous reset, active high
    input wire logic i_restart,      // Realign tick phase
    input wire logic [15:0] i_mult,  // Cycles per tick
    output logic o_tick              // Tick pulse
);

    logic [15:0] cnt_r;

    always_ff @(posedge i_clk) begin
        if (i_rst || i_restart) begin
            cnt_r <= `SSTC_ONE16;
            o_tick <= 1'b0;
        end else if (cnt_r >= i_mult) begin
            cnt_r <= `SSTC_ONE16;
            o_tick <= 1'b1;
        end else begin
            cnt_r <= cnt_r + `SSTC_ONE16;
            o_tick <= 1'b0;
        end
    end

    chk_tick_spacing: assert property (@(posedge i_clk) disable iff (i_rst)
        (o_tick && !i_restart && i_mult == 16'h0003)
        ##1 (!i_restart && i_mult == 16'h0003)[*2] |=> o_tick)
        else $error("tick period differs from multiplier");

    chk_tick_gap: assert property (@(posedge i_clk) disable iff (i_rst)
        (o_tick && !i_restart && i_mult == 16'h0003) |=> !o_tick)
        else $error("tick repeated too soon");

endmodule // sstc_tick_gen

`default_nettype wire

// *** core/sstc_timing_bank.sv ***
// Readout sequencer timing bank: registers, exposure timer, readout delay.
// Assumes the serial port delivers decoded word reads and writes.
//
// Overview of operation
// - Overlapped mode: wait the readout delay from transfer start.
// - Normal mode with post delay: wait the delay after transfer end.
// - Two-slope enable bit turns on dual slope, global shutter only.
// - Three-slope enable bit turns on triple slope, global only.
// - Period kind select: 0 reset length, 1 frame length, default 1.
// - Global shutter ticks last multiplier clock periods, default one.
// - Dark rows per frame, range 1 to 255, default 2.
// - Leading-row blanking bit, default 1, blanks the first line.
// - Filler rows 0 to 4095 appended only under rolling shutter.
// - Exposure counts line periods rolling, ticks global.
// - Second-slope time counts ticks in global dual slope only.
// - Overlap select 1 chooses overlapped, 0 normal transfer readout.
// - Post-transfer delay enable inserts delay in normal mode.
`include "sstc_map.svh"
`default_nettype none

module sstc_timing_bank (
    input wire logic i_clk,              // System clock, 250 MHz
    input wire logic i_rst,              // Synchronous reset, active high
    input wire logic i_reg_wr,           // Register write strobe
    input wire logic i_reg_rd,           // Register read strobe
    input wire logic [8:0] i_reg_addr,   // Register word address
    input wire logic [15:0] i_reg_wdata, // Register write data
    input wire logic i_rolling,          // 1 rolling, 0 global shutter
    input wire logic i_overlap_sel,      // 1 overlapped transfer readout
    input wire logic i_post_delay_en,    // Delay after transfer end
    input wire logic [7:0] i_xsm_delay,  // Readout-start delay, cycles
    input wire logic i_rot_start,        // Row transfer begins
    input wire logic i_rot_end,          // Row transfer ends
    input wire logic i_line_tick,        // One line period elapsed
    input wire logic i_frame_start,      // Start of exposure
    output logic [15:0] o_reg_rdata,     // Read data
    output logic o_reg_rvalid,           // Read data valid
    output sstc_pkg::sstc_cfg_t o_cfg,   // Effective configuration
    output logic o_readout_start,        // Horizontal readout start pulse
    output logic o_exposing,             // Exposure in progress
    output logic o_slope2,               // Second slope in progress
    output logic o_period_done           // Reset or frame length elapsed
);

    ////////////////////////////////////////////////////////////////////////
    // Register file

    logic [15:0] integ_ctrl_r;
    logic [15:0] window_r;
    logic [15:0] dark_r;
    logic [15:0] filler_r;
    logic [15:0] mult_r;
    logic [15:0] period_r;
    logic [15:0] integ_time_r;
    logic [15:0] slope2_time_r;

    always_ff @(posedge i_clk) begin
        if (i_rst) begin
            integ_ctrl_r <= `SSTC_RST_INTEG;
            window_r <= `SSTC_RST_WINDOW;
            dark_r <= `SSTC_RST_DARK;
            filler_r <= `SSTC_RST_FILLER;
            mult_r <= `SSTC_RST_MULT;
            period_r <= `SSTC_RST_PERIOD;
            integ_time_r <= `SSTC_RST_TIME;
            slope2_time_r <= `SSTC_RST_TIME;
        end else if (i_reg_wr) begin
            if (i_reg_addr == `SSTC_ADDR_INTEG) begin
                integ_ctrl_r <= i_reg_wdata & `SSTC_MASK_INTEG;
            end else if (i_reg_addr == `SSTC_ADDR_WINDOW) begin
                window_r <= i_reg_wdata & `SSTC_MASK_WINDOW;
            end else if (i_reg_addr == `SSTC_ADDR_DARK) begin
                dark_r <= i_reg_wdata & `SSTC_MASK_DARK;
            end else if (i_reg_addr == `SSTC_ADDR_FILLER) begin
                filler_r <= i_reg_wdata & `SSTC_MASK_FILLER;
            end else if (i_reg_addr == `SSTC_ADDR_MULT) begin
                mult_r <= i_reg_wdata;
            end else if (i_reg_addr == `SSTC_ADDR_PERIOD) begin
                period_r <= i_reg_wdata;
            end else if (i_reg_addr == `SSTC_ADDR_INTEG_TIME) begin
                integ_time_r <= i_reg_wdata;
            end else if (i_reg_addr == `SSTC_ADDR_SLOPE2_TIME) begin
                slope2_time_r <= i_reg_wdata;
            end
        end
    end

    // Read port; the reserved word and unmapped addresses read zero
    always_ff @(posedge i_clk) begin
        if (i_rst) begin
            o_reg_rdata <= `SSTC_ZERO16;
            o_reg_rvalid <= 1'b0;
        end else begin
            o_reg_rvalid <= i_reg_rd;
            if (!i_reg_rd) begin
                o_reg_rdata <= `SSTC_ZERO16;
            end else if (i_reg_addr == `SSTC_ADDR_INTEG) begin
                o_reg_rdata <= integ_ctrl_r;
            end else if (i_reg_addr == `SSTC_ADDR_WINDOW) begin
                o_reg_rdata <= window_r;
            end else if (i_reg_addr == `SSTC_ADDR_DARK) begin
                o_reg_rdata <= dark_r;
            end else if (i_reg_addr == `SSTC_ADDR_FILLER) begin
                o_reg_rdata <= filler_r;
            end else if (i_reg_addr == `SSTC_ADDR_MULT) begin
                o_reg_rdata <= mult_r;
            end else if (i_reg_addr == `SSTC_ADDR_PERIOD) begin
                o_reg_rdata <= period_r;
            end else if (i_reg_addr == `SSTC_ADDR_INTEG_TIME) begin
                o_reg_rdata <= integ_time_r;
            end else if (i_reg_addr == `SSTC_ADDR_SLOPE2_TIME) begin
                o_reg_rdata <= slope2_time_r;
            end else begin
                o_reg_rdata <= `SSTC_ZERO16;
            end
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Effective configuration

    logic dual_eff;
    logic [7:0] dark_field;

    assign dual_eff = integ_ctrl_r[`SSTC_BIT_DUAL] && !i_rolling;
    assign dark_field = dark_r[`SSTC_DARK_MSB:0];

    always_ff @(posedge i_clk) begin
        if (i_rst) begin
            o_cfg <= '0;
        end else begin
            o_cfg.dual_en <= dual_eff;
            o_cfg.triple_en <= integ_ctrl_r[`SSTC_BIT_TRIPLE]
                && !i_rolling;
            o_cfg.period_is_frame <= integ_ctrl_r[`SSTC_BIT_KIND];
            o_cfg.window_mask <= window_r[`SSTC_WINDOW_MSB:0];
            // A programmed zero is raised to the least legal count
            o_cfg.dark_rows <= (dark_field == `SSTC_ZERO8)
                ? `SSTC_DARK_MIN : dark_field;
            o_cfg.blank_first <= dark_r[`SSTC_BIT_BLANK];
            o_cfg.filler_rows <= i_rolling
                ? filler_r[`SSTC_FILLER_MSB:0] : 12'h000;
            o_cfg.tick_mult <= mult_r;
            o_cfg.period_len <= period_r;
            o_cfg.integ_time <= integ_time_r;
            o_cfg.slope2_time <= slope2_time_r;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Exposure and period timer

    logic gen_tick;
    logic unit_tick;
    logic [15:0] expo_cnt_r;
    sstc_pkg::sstc_expo_state_t expo_state_r;

    sstc_tick_gen u_tick (
        .i_clk(i_clk),
        .i_rst(i_rst),
        .i_restart(i_frame_start),
        .i_mult(mult_r),
        .o_tick(gen_tick)
    );

    assign unit_tick = i_rolling ? i_line_tick : gen_tick;

    always_ff @(posedge i_clk) begin
        if (i_rst) begin
            expo_state_r <= sstc_pkg::EX_IDLE;
            expo_cnt_r <= `SSTC_ZERO16;
            o_exposing <= 1'b0;
            o_slope2 <= 1'b0;
            o_period_done <= 1'b0;
        end else begin
            o_period_done <= 1'b0;
            if (i_frame_start) begin
                expo_state_r <= sstc_pkg::EX_FIRST;
                expo_cnt_r <= integ_time_r;
                o_exposing <= 1'b1;
                o_slope2 <= 1'b0;
            end else begin
                case (expo_state_r)
                    sstc_pkg::EX_FIRST: begin
                        if (expo_cnt_r != `SSTC_ZERO16) begin
                            if (unit_tick) begin
                                expo_cnt_r <= expo_cnt_r - `SSTC_ONE16;
                            end
                        end else if (dual_eff) begin
                            expo_state_r <= sstc_pkg::EX_SECOND;
                            expo_cnt_r <= slope2_time_r;
                            o_slope2 <= 1'b1;
                        end else if (!i_rolling) begin
                            expo_state_r <= sstc_pkg::EX_PERIOD;
                            expo_cnt_r <= period_r;
                            o_exposing <= 1'b0;
                        end else begin
                            expo_state_r <= sstc_pkg::EX_IDLE;
                            o_exposing <= 1'b0;
                        end
                    end
                    sstc_pkg::EX_SECOND: begin
                        if (expo_cnt_r != `SSTC_ZERO16) begin
                            if (gen_tick) begin
                                expo_cnt_r <= expo_cnt_r - `SSTC_ONE16;
                            end
                        end else begin
                            expo_state_r <= sstc_pkg::EX_PERIOD;
                            expo_cnt_r <= period_r;
                            o_exposing <= 1'b0;
                            o_slope2 <= 1'b0;
                        end
                    end
                    sstc_pkg::EX_PERIOD: begin
                        if (expo_cnt_r != `SSTC_ZERO16) begin
                            if (gen_tick) begin
                                expo_cnt_r <= expo_cnt_r - `SSTC_ONE16;
                            end
                        end else begin
                            expo_state_r <= sstc_pkg::EX_IDLE;
                            o_period_done <= 1'b1;
                        end
                    end
                    default: begin
                        expo_state_r <= sstc_pkg::EX_IDLE;
                    end
                endcase
            end
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Readout-start delay

    logic [7:0] rd_cnt_r;
    logic rd_trig;
    sstc_pkg::sstc_rd_state_t rd_state_r;

    // Overlapped counts from transfer start, normal from transfer end
    assign rd_trig = i_overlap_sel ? i_rot_start : i_rot_end;

    always_ff @(posedge i_clk) begin
        if (i_rst) begin
            rd_state_r <= sstc_pkg::RD_IDLE;
            rd_cnt_r <= `SSTC_ZERO8;
            o_readout_start <= 1'b0;
        end else begin
            o_readout_start <= 1'b0;
            case (rd_state_r)
                sstc_pkg::RD_IDLE: begin
                    if (rd_trig) begin
                        if ((i_overlap_sel || i_post_delay_en)
                            && i_xsm_delay != `SSTC_ZERO8) begin
                            rd_state_r <= sstc_pkg::RD_WAIT;
                            rd_cnt_r <= i_xsm_delay;
                        end else begin
                            o_readout_start <= 1'b1;
                        end
                    end
                end
                sstc_pkg::RD_WAIT: begin
                    if (rd_cnt_r <= `SSTC_ONE8) begin
                        rd_state_r <= sstc_pkg::RD_IDLE;
                        o_readout_start <= 1'b1;
                    end else begin
                        rd_cnt_r <= rd_cnt_r - `SSTC_ONE8;
                    end
                end
                default: begin
                    rd_state_r <= sstc_pkg::RD_IDLE;
                end
            endcase
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Checks

    chk_ovl_delay: assert property (@(posedge i_clk) disable iff (i_rst)
        (rd_state_r == sstc_pkg::RD_IDLE && i_overlap_sel && i_rot_start
        && i_xsm_delay == 8'h03)
        |=> !o_readout_start ##1 !o_readout_start ##1 !o_readout_start
        ##1 o_readout_start)
        else $error("overlapped readout start not after delay");

    chk_norm_delay: assert property (@(posedge i_clk) disable iff (i_rst)
        (rd_state_r == sstc_pkg::RD_IDLE && !i_overlap_sel && i_rot_end
        && i_post_delay_en && i_xsm_delay == 8'h01)
        |=> !o_readout_start ##1 o_readout_start)
        else $error("post transfer delay not applied");

    chk_norm_direct: assert property (@(posedge i_clk) disable iff (i_rst)
        (rd_state_r == sstc_pkg::RD_IDLE && !i_overlap_sel && i_rot_end
        && !i_post_delay_en) |=> o_readout_start)
        else $error("normal readout start delayed without enable");

    chk_ovl_ignore_end: assert property (@(posedge i_clk) disable iff (i_rst)
        (rd_state_r == sstc_pkg::RD_IDLE && i_overlap_sel && !i_rot_start)
        |=> !o_readout_start)
        else $error("readout started without transfer start");

    chk_roll_slopes: assert property (@(posedge i_clk) disable iff (i_rst)
        i_rolling |=> (!o_cfg.dual_en && !o_cfg.triple_en))
        else $error("slope modes active under rolling shutter");

    chk_filler_gate: assert property (@(posedge i_clk) disable iff (i_rst)
        !i_rolling |=> o_cfg.filler_rows == 12'h000)
        else $error("filler rows under global shutter");

    chk_dark_floor: assert property (@(posedge i_clk) disable iff (i_rst)
        !i_rst |=> o_cfg.dark_rows != 8'h00)
        else $error("dark row count below one");

    chk_reg_readback: assert property (@(posedge i_clk) disable iff (i_rst)
        (i_reg_wr && i_reg_addr == `SSTC_ADDR_DARK) ##1 !i_reg_wr
        ##1 (i_reg_rd && !i_reg_wr && i_reg_addr == `SSTC_ADDR_DARK)
        |=> o_reg_rvalid
        && o_reg_rdata == ($past(i_reg_wdata, 3) & `SSTC_MASK_DARK))
        else $error("dark row register read back wrong");

    chk_reset_kind: assert property (@(posedge i_clk)
        i_rst |=> integ_ctrl_r == 16'h0004 && dark_r == 16'h0102)
        else $error("reset value wrong");

    chk_expo_start: assert property (@(posedge i_clk) disable iff (i_rst)
        i_frame_start |=> o_exposing && !o_slope2)
        else $error("exposure did not start");

endmodule // sstc_timing_bank

`default_nettype wire

// *** tb/sstc_timing_bank_tb.sv ***
// Self-checking bench for the sequencer timing register bank.
// Assumes the bank's word port, readout delay and exposure timer contract.
`default_nettype none

module sstc_timing_bank_tb;
    timeunit 1ns;
    timeprecision 100ps;

    logic i_clk = 1'b0;
    logic i_rst = 1'b1;
    logic i_reg_wr = 1'b0;
    logic i_reg_rd = 1'b0;
    logic [8:0] i_reg_addr = 9'h000;
    logic [15:0] i_reg_wdata = 16'h0000;
    logic i_rolling = 1'b0;
    logic i_overlap_sel = 1'b0;
    logic i_post_delay_en = 1'b0;
    logic [7:0] i_xsm_delay = 8'h00;
    logic i_rot_start = 1'b0;
    logic i_rot_end = 1'b0;
    logic i_line_tick = 1'b0;
    logic i_frame_start = 1'b0;
    logic [15:0] o_reg_rdata;
    logic o_reg_rvalid;
    sstc_pkg::sstc_cfg_t o_cfg;
    logic o_readout_start;
    logic o_exposing;
    logic o_slope2;
    logic o_period_done;
    int err_total = 0;
    int n_checks = 0;
    int cyc = 0;

    sstc_timing_bank i_dut (
        .i_clk(i_clk), .i_rst(i_rst), .i_reg_wr(i_reg_wr),
        .i_reg_rd(i_reg_rd), .i_reg_addr(i_reg_addr),
        .i_reg_wdata(i_reg_wdata), .i_rolling(i_rolling),
        .i_overlap_sel(i_overlap_sel), .i_post_delay_en(i_post_delay_en),
        .i_xsm_delay(i_xsm_delay), .i_rot_start(i_rot_start),
        .i_rot_end(i_rot_end), .i_line_tick(i_line_tick),
        .i_frame_start(i_frame_start), .o_reg_rdata(o_reg_rdata),
        .o_reg_rvalid(o_reg_rvalid), .o_cfg(o_cfg),
        .o_readout_start(o_readout_start), .o_exposing(o_exposing),
        .o_slope2(o_slope2), .o_period_done(o_period_done)
    );

    initial begin
        forever #2 i_clk = ~i_clk;
    end

    ////////////////////////////////////////////////////////////////////////
    task automatic finish_test();
        $display("checks %0d errors %0d", n_checks, err_total);
        if (err_total == 0 && n_checks > 0) begin
            $display("bench passed");
        end else begin
            $display("bench failed");
        end
        $finish;
    endtask

    // Hang guard: the whole run needs well under this many cycles
    always @(posedge i_clk) begin
        cyc <= cyc + 1;
        if (cyc == 20000) begin
            err_total++;
            finish_test();
        end
    end

    task automatic check(input string name, input logic [31:0] seen,
                         input logic [31:0] exp);
        n_checks++;
        if (seen !== exp) begin
            err_total++;
            $display("wrong value %s expected %0h seen %0h", name, exp, seen);
        end
    endtask

    task automatic reg_wr(input logic [8:0] a, input logic [15:0] d);
        @(posedge i_clk);
        i_reg_wr <= 1'b1;
        i_reg_addr <= a;
        i_reg_wdata <= d;
        @(posedge i_clk);
        i_reg_wr <= 1'b0;
    endtask

    task automatic reg_rd(input logic [8:0] a, input logic [15:0] exp);
        @(posedge i_clk);
        i_reg_rd <= 1'b1;
        i_reg_addr <= a;
        @(posedge i_clk);
        i_reg_rd <= 1'b0;
        #1;
        check("rvalid", o_reg_rvalid, 1'b1);
        check("rdata", o_reg_rdata, exp);
    endtask

    task automatic settle();
        repeat (3) @(posedge i_clk);
        #1;
    endtask

    // Pulse one trigger for a cycle, then count edges until the watched
    // output shows; 60 means it never showed
    task automatic run(input int drv, input int sel, output int n);
        @(posedge i_clk);
        case (drv)
            0: i_rot_start <= 1'b1;
            1: i_rot_end <= 1'b1;
            default: i_frame_start <= 1'b1;
        endcase
        for (n = 1; n < 60; n++) begin
            @(posedge i_clk);
            i_rot_start <= 1'b0;
            i_rot_end <= 1'b0;
            i_frame_start <= 1'b0;
            #1;
            if (sel == 0 && o_readout_start === 1'b1) break;
            if (sel == 1 && o_period_done === 1'b1) break;
            if (sel == 2 && o_exposing === 1'b0) break;
            if (sel == 3 && o_slope2 === 1'b1) break;
        end
    endtask

    ////////////////////////////////////////////////////////////////////////
    task automatic test_reset_values();
        logic [15:0] rv [10] = '{16'h0004, 16'h0001, 16'h0000, 16'h0102,
            16'h0000, 16'h0001, 16'h0000, 16'h0000, 16'h0000, 16'h0000};
        for (int i = 0; i < 10; i++) begin
            reg_rd(9'h0C2 + 9'(i), rv[i]);
        end
        check("kind", o_cfg.period_is_frame, 1'b1);
        check("window", o_cfg.window_mask, 8'h01);
        check("mult", o_cfg.tick_mult, 16'h0001);
        check("dark", o_cfg.dark_rows, 8'h02);
        check("blank", o_cfg.blank_first, 1'b1);
        check("filler", o_cfg.filler_rows, 12'h000);
    endtask

    task automatic test_write_masks();
        logic [15:0] mv [10] = '{16'h0007, 16'h00FF, 16'h0000, 16'h01FF,
            16'h0FFF, 16'hFFFF, 16'hFFFF, 16'hFFFF, 16'hFFFF, 16'h0000};
        for (int i = 0; i < 10; i++) begin
            reg_wr(9'h0C2 + 9'(i), 16'hFFFF);
            reg_rd(9'h0C2 + 9'(i), mv[i]);
        end
        settle();
        check("dual_g", o_cfg.dual_en, 1'b1);
        check("triple_g", o_cfg.triple_en, 1'b1);
        check("filler_g", o_cfg.filler_rows, 12'h000);
        check("window_g", o_cfg.window_mask, 8'hFF);
        check("mult_g", o_cfg.tick_mult, 16'hFFFF);
        check("period_g", o_cfg.period_len, 16'hFFFF);
        check("integ_g", o_cfg.integ_time, 16'hFFFF);
        check("slope2_g", o_cfg.slope2_time, 16'hFFFF);
        @(posedge i_clk);
        i_rolling <= 1'b1;
        reg_wr(9'h0C5, 16'h0000);
        settle();
        check("dual_r", o_cfg.dual_en, 1'b0);
        check("triple_r", o_cfg.triple_en, 1'b0);
        check("filler_r", o_cfg.filler_rows, 12'hFFF);
        check("dark0", o_cfg.dark_rows, 8'h01);
        check("blank0", o_cfg.blank_first, 1'b0);
        reg_wr(9'h0C2, 16'h0000);
        settle();
        check("kind0", o_cfg.period_is_frame, 1'b0);
        @(posedge i_clk);
        i_rolling <= 1'b0;
    endtask

    task automatic test_mid_reset();
        @(posedge i_clk);
        i_rst <= 1'b1;
        repeat (2) @(posedge i_clk);
        i_rst <= 1'b0;
        @(posedge i_clk);
        #1;
        check("rst_kind", o_cfg.period_is_frame, 1'b1);
        check("rst_dark", o_cfg.dark_rows, 8'h02);
        check("rst_blank", o_cfg.blank_first, 1'b1);
        check("rst_mult", o_cfg.tick_mult, 16'h0001);
        reg_rd(9'h0C5, 16'h0102);
        @(posedge i_clk);
        #1;
        check("rd_idle_valid", o_reg_rvalid, 1'b0);
        check("rd_idle_data", o_reg_rdata, 16'h0000);
    endtask

    task automatic test_readout_delay();
        int n;
        @(posedge i_clk);
        i_xsm_delay <= 8'h03;
        i_overlap_sel <= 1'b1;
        run(0, 0, n);
        check("ovl_delay", n, 4);
        run(1, 0, n);
        check("ovl_ignore_end", n, 60);
        @(posedge i_clk);
        i_overlap_sel <= 1'b0;
        i_post_delay_en <= 1'b1;
        i_xsm_delay <= 8'h01;
        run(1, 0, n);
        check("post_delay", n, 2);
        @(posedge i_clk);
        i_post_delay_en <= 1'b0;
        run(1, 0, n);
        check("no_delay", n, 1);
    endtask

    task automatic test_global_exposure();
        int n;
        reg_wr(9'h0C2, 16'h0004);
        reg_wr(9'h0C7, 16'h0003);
        reg_wr(9'h0C9, 16'h0003);
        run(2, 2, n);
        check("expo_ticks", n, 12);
        reg_wr(9'h0C7, 16'h0001);
        reg_wr(9'h0C9, 16'h0001);
        reg_wr(9'h0C8, 16'h0002);
        run(2, 1, n);
        check("period_done", n, 7);
        reg_wr(9'h0C2, 16'h0005);
        reg_wr(9'h0CA, 16'h0002);
        run(2, 3, n);
        check("slope2_start", n, 4);
        check("slope2_expo", o_exposing, 1'b1);
        repeat (3) @(posedge i_clk);
        #1;
        check("slope2_end", o_exposing, 1'b0);
        check("slope2_drop", o_slope2, 1'b0);
    endtask

    task automatic test_rolling_exposure();
        int n;
        @(posedge i_clk);
        i_rolling <= 1'b1;
        reg_wr(9'h0C9, 16'h0002);
        run(2, 2, n);
        check("roll_hold", n, 60);
        check("roll_slope2", o_slope2, 1'b0);
        repeat (2) begin
            @(posedge i_clk);
            i_line_tick <= 1'b1;
            @(posedge i_clk);
            i_line_tick <= 1'b0;
        end
        settle();
        check("roll_end", o_exposing, 1'b0);
        @(posedge i_clk);
        i_rolling <= 1'b0;
    endtask

    ////////////////////////////////////////////////////////////////////////
    initial begin
        repeat (2) @(posedge i_clk);
        i_rst <= 1'b0;
        settle();
        test_reset_values();
        test_write_masks();
        test_mid_reset();
        test_readout_delay();
        test_global_exposure();
        test_rolling_exposure();
        finish_test();
    end

endmodule // sstc_timing_bank_tb

`default_nettype wire
